//--- core/sffe_pkg.sv
// Constants, types and decode tables for the serial flash front end
// Behaviour
// - Unknown opcode: go standby, float output, ignore bus until chip select rises.
// - Known opcode: stay active until chip select rises.
// - Modes 0 and 3: sample on rising clock, shift out on falling clock.
// - Dual opcodes switch lanes 0 and 1 to two bits per clock; here lanes 0 and 1 still carry one bit per clock.
// - Quad opcodes use lanes 0 to 3, including guard and pause pins; here frames still move one bit per clock, in on lane 0 and out on lane 1.
// - Quad commands run only with four-lane enable set; host sets it first.
// - Pause stops serial traffic but not a running status write, program or erase.
// - Pause starts on falling pause pin with clock low, else waits for clock low.
// - Pause ends on rising pause pin with clock low, else waits for clock low.
// - While paused the serial output floats from pause pin fall until it rises.
// - Serial input ignored from clock and pause low until clock low and pause high.
// - Chip select high during pause resets interface; resume needs pause high, select low.
// - Pause function disabled in quad lane mode.
// - Sixteen-bit status word in the documented bit order.
// - Busy bit is one while program, erase or status write runs.
// - Write latch clear rejects status write, program and erase.
// - Program and erases blocked inside the protected array region.
// - Chip erase only when no area is protected.
// - Protect bits rewritable only outside hardware protection.
// - Protect-mode bits: soft, pin-guarded, locked till power cycle, permanent.
// - Power cycle returns lock-down protect mode to unprotected code.
// - Four-lane enable off keeps guard and pause pins; on makes them lanes.
// - Write unlock command sets the write latch before any modifying command.
package sffe_pkg;

	// Status word field positions
	localparam int BUSY_BIT = 0;
	localparam int LATCH_BIT = 1;
	localparam int PROT_LSB = 2;
	localparam int GUARD_LO_BIT = 7;
	localparam int GUARD_HI_BIT = 8;
	localparam int QUAD_BIT = 9;
	localparam int PSUS_BIT = 10;
	localparam int LOCK_LSB = 11;
	localparam int INV_BIT = 14;
	localparam int ESUS_BIT = 15;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] SW_WR_MASK = 16'h43FC;
	localparam logic [15:0] SW_LOCK_MASK = 16'h3800;

	// Protect-mode codes
	localparam logic [1:0] GUARD_SOFT = 2'h0;
	localparam logic [1:0] GUARD_PIN = 2'h1;
	localparam logic [1:0] GUARD_POWER = 2'h2;
	localparam logic [1:0] GUARD_OTP = 2'h3;

	// Opcodes
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
	localparam logic [7:0] OP_STAT_RD_LO = 8'h05;
	localparam logic [7:0] OP_STAT_RD_HI = 8'h35;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_STAT_WR_HI = 8'h31;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DUAL_ID = 8'h92;
	localparam logic [7:0] OP_DUAL_PROG = 8'hA2;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_WORD = 8'hE7;
	localparam logic [7:0] OP_QUAD_OCTAL = 8'hE3;
	localparam logic [7:0] OP_QUAD_ID = 8'h94;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;

	// Frame clock counts
	localparam logic [5:0] OPC_CLOCKS = 6'h08;
	localparam logic [5:0] WR_ONE_CLOCKS = 6'h10;
	localparam logic [5:0] WR_TWO_CLOCKS = 6'h18;
	localparam logic [5:0] ADDR_CLOCKS = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3F;

	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS = 2100000;
	localparam int ERASE_TIME_NS = 13000000;
	localparam int PROG_TIME_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_TIME_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {LANE_ONE, LANE_TWO, LANE_FOUR} sffe_lane_t;
	typedef enum logic {ST_READY, ST_BUSY} sffe_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [5:0] clocks;
		logic [23:0] arg;
	} sffe_frame_t;

	typedef struct packed {
		logic [7:0] code;
		logic [23:0] addr;
	} sffe_op_t;

endpackage

//--- core/sffe_front_end.sv
// Serial flash front end: pin-level link logic and status word protection
`timescale 1ns/10ps
module sffe_front_end
	import sffe_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_TIME_CYC,
	parameter int unsigned ERASE_CYCLES = ERASE_TIME_CYC,
	parameter int unsigned STATUS_WRITE_CYCLES = 200
) (
	// System clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic power_cycle_in,
	// Serial pins
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_out,
	// Array side
	output logic op_start_out,
	output sffe_op_t op_out,
	output logic busy_out,
	output logic [15:0] status_out
);

	// Opcode known to the front end; quad opcodes need four-lane enable
	function automatic logic op_known(input logic [7:0] op, input logic qe);
		logic k;
		k = 1'b0;
		unique case (op)
			OP_WRITE_UNLOCK, OP_WRITE_LOCK, OP_STAT_RD_LO, OP_STAT_RD_HI,
			OP_STAT_WR, OP_STAT_WR_HI, OP_READ, OP_FAST_READ, OP_DUAL_OUT,
			OP_DUAL_IO, OP_DUAL_ID, OP_DUAL_PROG, OP_PAGE_PROG, OP_PAGE_ERASE,
			OP_SECT_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE_A,
			OP_CHIP_ERASE_B: k = 1'b1;
			OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_OCTAL, OP_QUAD_ID,
			OP_QUAD_PROG: k = qe;
			default: k = 1'b0;
		endcase
		return k;
	endfunction

	function automatic sffe_lane_t op_lanes(input logic [7:0] op);
		sffe_lane_t l;
		l = LANE_ONE;
		unique case (op)
			OP_DUAL_OUT, OP_DUAL_IO, OP_DUAL_ID, OP_DUAL_PROG: l = LANE_TWO;
			OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_OCTAL, OP_QUAD_ID,
			OP_QUAD_PROG: l = LANE_FOUR;
			default: l = LANE_ONE;
		endcase
		return l;
	endfunction

	// Address falls in the area chosen by the protect field and invert bit
	function automatic logic prot_hit(input logic [15:0] sw, input logic [23:0] addr);
		logic [2:0] sel;
		logic [6:0] span;
		logic [6:0] blk;
		logic hit;
		sel = sw[PROT_LSB +: 3];
		blk = {1'b0, addr[21:16]};
		span = 7'h01 << (sel - 3'h1);
		if (sel == 3'h0) begin
			hit = 1'b0;
		end else if (sw[PROT_LSB + 3]) begin
			hit = blk < span;
		end else begin
			hit = blk >= (7'h40 - span);
		end
		return hit ^ sw[INV_BIT];
	endfunction

	// Link domain, clocked by the host's serial clock
	logic first_r;
	logic standby_r;
	sffe_lane_t lane_r;
	logic paused_r;
	logic oe_r;
	logic frame_tog_r;
	logic [5:0] count_r;
	logic [5:0] count_cur;
	logic [5:0] count_nxt;
	logic [7:0] op_r;
	logic [23:0] arg_r;
	logic [7:0] sh_r;
	logic [15:0] st_meta_r;
	logic [15:0] st_sync_r;
	logic hold_en;
	logic hold_n;
	logic pause_now;
	logic in_ok;
	logic rd_status;
	sffe_frame_t frame;

	assign hold_n = io_in[3];
	assign hold_en = ~st_sync_r[QUAD_BIT] & (lane_r != LANE_FOUR);
	// Start and end both wait for the clock to be low
	assign pause_now = hold_en & ((~hold_n & ~sclk_in) | (paused_r & (sclk_in | ~hold_n)));
	assign in_ok = ~standby_r & (~hold_en | hold_n);
	assign count_cur = first_r ? 6'h00 : count_r;
	assign count_nxt = (count_cur == CNT_MAX) ? CNT_MAX : count_cur + 6'h01;
	assign rd_status = (op_r == OP_STAT_RD_LO) | (op_r == OP_STAT_RD_HI);
	assign frame = '{opcode: op_r, clocks: count_r, arg: arg_r};

	// Chip select high clears the interface, paused or not
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			first_r <= 1'b1;
			standby_r <= 1'b0;
			lane_r <= LANE_ONE;
		end else if (in_ok) begin
			first_r <= 1'b0;
			if (count_cur == OPC_CLOCKS - 6'h01) begin
				standby_r <= ~op_known({op_r[6:0], io_in[0]}, st_sync_r[QUAD_BIT]);
				lane_r <= op_lanes({op_r[6:0], io_in[0]});
			end
		end
	end

	// Frame content is left standing after chip select rises for the system side
	always_ff @(posedge sclk_in) begin
		if (in_ok) begin
			count_r <= count_nxt;
			if (count_cur < OPC_CLOCKS) begin
				op_r <= {op_r[6:0], io_in[0]};
			end else if (count_cur < ADDR_CLOCKS) begin
				arg_r <= {arg_r[22:0], io_in[0]};
			end
		end
	end

	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			frame_tog_r <= 1'b0;
		end else if (in_ok && first_r && !cs_n_in) begin
			frame_tog_r <= ~frame_tog_r;
		end
	end

	// Status copy; a change reaches the link after two serial clocks
	always_ff @(posedge sclk_in) begin
		st_meta_r <= status_out;
		st_sync_r <= st_meta_r;
	end

	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			paused_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			paused_r <= hold_en & ~hold_n;
			oe_r <= ~standby_r & rd_status & (count_cur >= OPC_CLOCKS);
		end
	end

	// Status bytes repeat every eight clocks while select stays low, until the clock count saturates at 63
	always_ff @(negedge sclk_in) begin
		if (!(hold_en && !hold_n)) begin
			if (count_cur[2:0] == 3'h0) begin
				sh_r <= (op_r == OP_STAT_RD_HI) ? st_sync_r[15:8] : st_sync_r[7:0];
			end else begin
				sh_r <= {sh_r[6:0], 1'b0};
			end
		end
	end

	// Only the status read drives data; array reads are served outside this block
	assign io_out = {2'b00, sh_r[7], 1'b0};
	assign io_oe_out = {2'b00, oe_r & ~cs_n_in & ~pause_now & ~(hold_en & ~hold_n), 1'b0};

	// System domain
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic tog_meta_r;
	logic tog_sync_r;
	logic tog_seen_r;
	logic wp_meta_r;
	logic wp_sync_r;
	logic [15:0] sw_r;
	sffe_state_t state_r;
	logic [31:0] busy_cnt_r;
	logic frame_end;
	logic known;
	logic write_ok;
	logic guard_ok;
	logic prot_none;
	logic do_unlock;
	logic do_lock;
	logic do_stat_wr;
	logic do_prog;
	logic do_erase;
	logic do_chip;
	logic [15:0] wr_word;
	logic [15:0] wr_mask;
	logic [31:0] run_len;

	always_ff @(posedge clk_sys_in) begin
		cs_meta_r <= cs_n_in;
		cs_sync_r <= cs_meta_r;
		cs_prev_r <= cs_sync_r;
		tog_meta_r <= frame_tog_r;
		tog_sync_r <= tog_meta_r;
		wp_meta_r <= io_in[2];
		wp_sync_r <= wp_meta_r;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tog_seen_r <= 1'b0;
		end else if (frame_end) begin
			tog_seen_r <= tog_sync_r;
		end
	end

	assign frame_end = cs_sync_r & ~cs_prev_r & (tog_sync_r != tog_seen_r);
	assign known = frame_end & (frame.clocks >= OPC_CLOCKS) &
		op_known(frame.opcode, sw_r[QUAD_BIT]);
	assign write_ok = sw_r[LATCH_BIT] & (state_r == ST_READY);
	assign prot_none = (sw_r[PROT_LSB +: 3] == 3'h0) & ~sw_r[INV_BIT];

	always_comb begin
		unique case (sw_r[GUARD_HI_BIT:GUARD_LO_BIT])
			GUARD_SOFT: guard_ok = 1'b1;
			GUARD_PIN: guard_ok = sw_r[QUAD_BIT] | wp_sync_r;
			GUARD_POWER: guard_ok = 1'b0;
			GUARD_OTP: guard_ok = 1'b0;
		endcase
	end

	always_comb begin
		wr_word = STATUS_RESET;
		wr_mask = 16'h0000;
		if (frame.opcode == OP_STAT_WR_HI) begin
			wr_word = {frame.arg[7:0], 8'h00};
			wr_mask = 16'hFF00;
		end else if (frame.clocks == WR_TWO_CLOCKS) begin
			// First data byte is the low half, second the high half
			wr_word = {frame.arg[7:0], frame.arg[15:8]};
			wr_mask = 16'hFFFF;
		end else begin
			wr_word = {8'h00, frame.arg[7:0]};
			wr_mask = 16'h00FF;
		end
	end

	assign do_unlock = known & (frame.opcode == OP_WRITE_UNLOCK) &
		(frame.clocks == OPC_CLOCKS) & (state_r == ST_READY);
	assign do_lock = known & (frame.opcode == OP_WRITE_LOCK) & (frame.clocks == OPC_CLOCKS);
	assign do_stat_wr = known & write_ok & guard_ok & (
		((frame.opcode == OP_STAT_WR) &
			((frame.clocks == WR_ONE_CLOCKS) | (frame.clocks == WR_TWO_CLOCKS))) |
		((frame.opcode == OP_STAT_WR_HI) & (frame.clocks == WR_ONE_CLOCKS)));
	assign do_prog = known & write_ok & (frame.clocks > ADDR_CLOCKS) &
		((frame.opcode == OP_PAGE_PROG) | (frame.opcode == OP_DUAL_PROG) |
		(frame.opcode == OP_QUAD_PROG)) & ~prot_hit(sw_r, frame.arg);
	assign do_erase = known & write_ok & (frame.clocks == ADDR_CLOCKS) &
		((frame.opcode == OP_PAGE_ERASE) | (frame.opcode == OP_SECT_ERASE) |
		(frame.opcode == OP_HALF_ERASE) | (frame.opcode == OP_BLOCK_ERASE)) &
		~prot_hit(sw_r, frame.arg);
	assign do_chip = known & write_ok & (frame.clocks == OPC_CLOCKS) & prot_none &
		((frame.opcode == OP_CHIP_ERASE_A) | (frame.opcode == OP_CHIP_ERASE_B));

	always_comb begin
		if (do_prog) begin
			run_len = 32'(PROG_CYCLES);
		end else if (do_stat_wr) begin
			run_len = 32'(STATUS_WRITE_CYCLES);
		end else begin
			run_len = 32'(ERASE_CYCLES);
		end
	end

	// Status word; suspend flags stay clear as suspend is not handled here
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sw_r <= STATUS_RESET;
		end else if (power_cycle_in) begin
			sw_r[LATCH_BIT] <= 1'b0;
			if (sw_r[GUARD_HI_BIT:GUARD_LO_BIT] == GUARD_POWER) begin
				sw_r[GUARD_HI_BIT:GUARD_LO_BIT] <= GUARD_SOFT;
			end
		end else if (do_stat_wr) begin
			sw_r <= (sw_r & ~(wr_mask & SW_WR_MASK)) | (wr_word & wr_mask & SW_WR_MASK) |
				(wr_word & wr_mask & SW_LOCK_MASK);
			sw_r[LATCH_BIT] <= 1'b0;
		end else if (do_prog || do_erase || do_chip || do_lock) begin
			sw_r[LATCH_BIT] <= 1'b0;
		end else if (do_unlock) begin
			sw_r[LATCH_BIT] <= 1'b1;
		end
	end

	// Internal operation runs on regardless of the pause pin
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_r <= ST_READY;
			busy_cnt_r <= 32'h00000000;
		end else begin
			unique case (state_r)
				ST_READY: begin
					if (do_stat_wr || do_prog || do_erase || do_chip) begin
						state_r <= ST_BUSY;
						busy_cnt_r <= run_len;
					end
				end
				ST_BUSY: begin
					if (busy_cnt_r <= 32'h00000001) begin
						state_r <= ST_READY;
					end
					busy_cnt_r <= busy_cnt_r - 32'h00000001;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			op_start_out <= 1'b0;
			op_out <= '{code: 8'h00, addr: 24'h000000};
		end else begin
			op_start_out <= do_prog | do_erase | do_chip;
			if (do_prog || do_erase || do_chip) begin
				op_out <= '{code: frame.opcode, addr: frame.arg};
			end
		end
	end

	assign busy_out = (state_r == ST_BUSY);
	assign status_out = {sw_r[15:1], busy_out};

endmodule // sffe_front_end

//--- verif/sffe_host_model.sv
// Host controller model driving the serial pins of the front end
`timescale 1ns/10ps
module sffe_host_model (
	// Device drive
	input wire logic [3:0] dev_out_in,
	input wire logic [3:0] dev_oe_in,
	// Serial pins
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] pins_out
);
	logic si_r;
	logic wp_n_r;
	logic hold_n_r;
	logic last1_r;
	logic oe_seen_r;
	logic oe_in_hold_r;
	// Released output line has no pull, so show the inverse of its last value
	assign pins_out = {hold_n_r, wp_n_r, dev_oe_in[1] ? dev_out_in[1] : ~last1_r, si_r};
	always @* begin
		if (dev_oe_in[1]) begin
			last1_r = dev_out_in[1];
		end
	end
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_r = 1'b0;
		wp_n_r = 1'b1;
		hold_n_r = 1'b1;
		last1_r = 1'b0;
		oe_seen_r = 1'b0;
		oe_in_hold_r = 1'b0;
	end
	// Bit i of the frame is tx[39-i]; serial clock only runs inside frames
	task automatic xfer(input logic [39:0] tx, input int nbits, input logic cpol,
			input int hold_bit, output logic [7:0] rx);
		sclk_out = cpol;
		#16;
		cs_n_out = 1'b0;
		oe_seen_r = 1'b0;
		rx = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			sclk_out = 1'b0;
			si_r = tx[39-i];
			if (i == hold_bit) begin
				#8;
				hold_n_r = 1'b0;
				si_r = ~si_r;
				#16;
				oe_in_hold_r = dev_oe_in[1];
				si_r = tx[39-i];
				hold_n_r = 1'b1;
			end
			#16;
			sclk_out = 1'b1;
			rx = {rx[6:0], pins_out[1]};
			oe_seen_r = oe_seen_r | dev_oe_in[1];
			#16;
		end
		sclk_out = cpol;
		#16;
		cs_n_out = 1'b1;
	endtask
endmodule // sffe_host_model

//--- verif/sffe_properties.sv
// Port-level checker for the serial flash front end
`timescale 1ns/10ps
module sffe_checker
	import sffe_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = 20,
	parameter int unsigned ERASE_CYCLES = 30,
	parameter int unsigned STATUS_WRITE_CYCLES = 10
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic power_cycle_in,
	// Serial pins
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_out,
	// Array side
	input wire logic op_start_out,
	input wire sffe_op_t op_out,
	input wire logic busy_out,
	input wire logic [15:0] status_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	// Loose bound, but catches a busy flag that never drops
	logic [31:0] busy_len_r;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !busy_out) begin
			busy_len_r <= 32'h0;
		end else begin
			busy_len_r <= busy_len_r + 32'h1;
		end
	end
	sequence s_accept;
		op_start_out ##1 busy_out;
	endsequence
	property p_cs_float; cs_n_in |-> io_oe_out == 4'h0; endproperty
	a_cs_float: assert property (p_cs_float) else $error("output driven while deselected");
	property p_pause_float; !io_in[3] && !status_out[QUAD_BIT] |-> !io_oe_out[1]; endproperty
	a_pause_float: assert property (p_pause_float) else $error("output driven in pause");
	property p_start_busy; op_start_out |-> s_accept ##1 busy_out; endproperty
	a_start_busy: assert property (p_start_busy) else $error("no busy after start");
	property p_busy_flag; busy_out [*3] |-> status_out[BUSY_BIT]; endproperty
	a_busy_flag: assert property (p_busy_flag) else $error("busy bit not shown");
	property p_start_idle; op_start_out |-> !$past(busy_out); endproperty
	a_start_idle: assert property (p_start_idle) else $error("start while busy");
	property p_latch_gate;
		$rose(busy_out) |-> $past(status_out[LATCH_BIT], 1) || $past(status_out[LATCH_BIT], 2);
	endproperty
	a_latch_gate: assert property (p_latch_gate) else $error("busy without latch");
	property p_latch_clear; op_start_out |-> ##[0:3] !status_out[LATCH_BIT]; endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch kept after start");
	property p_chip_erase;
		op_start_out && (op_out.code == OP_CHIP_ERASE_A || op_out.code == OP_CHIP_ERASE_B)
			|-> status_out[4:2] == 3'h0 && !status_out[INV_BIT];
	endproperty
	a_chip_erase: assert property (p_chip_erase) else $error("chip erase while protected");
	property p_power_hold;
		$past(status_out[8:7]) == GUARD_POWER && !$past(power_cycle_in, 1) && !$past(power_cycle_in, 2)
			|-> status_out[8:2] == $past(status_out[8:2]);
	endproperty
	a_power_hold: assert property (p_power_hold) else $error("locked status changed");
	property p_power_release;
		status_out[8:7] == GUARD_POWER && power_cycle_in |-> ##[1:3] status_out[8:7] == GUARD_SOFT;
	endproperty
	a_power_release: assert property (p_power_release) else $error("lock kept on power cycle");
	property p_busy_bound; busy_len_r <= ERASE_CYCLES + PROG_CYCLES + STATUS_WRITE_CYCLES; endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule // sffe_checker
bind sffe_front_end sffe_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
	.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
	.power_cycle_in(power_cycle_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .io_in(io_in),
	.io_out(io_out), .io_oe_out(io_oe_out), .op_start_out(op_start_out), .op_out(op_out),
	.busy_out(busy_out), .status_out(status_out));

//--- verif/tb_top.sv
// Self-checking testbench for the serial flash front end
`timescale 1ns/10ps
module tb_top;
	import sffe_pkg::*;
	localparam int SW_CYC = 10;
	localparam int ER_CYC = 30;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b0;
	logic power_cycle_in = 1'b0;
	logic sclk;
	logic cs_n;
	logic [3:0] io_pins;
	logic [3:0] io_out;
	logic [3:0] io_oe;
	logic op_start;
	logic busy;
	sffe_op_t op;
	sffe_op_t last_op;
	logic [15:0] status;
	logic [15:0] exp;
	logic [7:0] rx;
	int errors = 0;
	int n_compared = 0;
	int n_start = 0;
	int busy_len = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	sffe_front_end #(.PROG_CYCLES(20), .ERASE_CYCLES(ER_CYC), .STATUS_WRITE_CYCLES(SW_CYC)) u_dut (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .power_cycle_in(power_cycle_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_pins), .io_out(io_out), .io_oe_out(io_oe),
		.op_start_out(op_start), .op_out(op), .busy_out(busy), .status_out(status));
	sffe_host_model u_host (.dev_out_in(io_out), .dev_oe_in(io_oe), .sclk_out(sclk),
		.cs_n_out(cs_n), .pins_out(io_pins));
	always @(posedge clk_sys_in) begin
		if (op_start === 1'b1) begin
			n_start++;
			last_op = op;
		end
		if (busy === 1'b1) begin
			busy_len++;
		end
	end
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One frame, then wait for the command to land and any busy period to end
	task automatic cmd(input logic [39:0] tx, input int nbits, input logic cpol = 1'b0,
			input int hb = -1);
		int i;
		u_host.xfer(tx, nbits, cpol, hb, rx);
		repeat (30) @(negedge clk_sys_in);
		for (i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(negedge clk_sys_in);
		end
		if (i == 400) begin
			errors++;
			tally_and_finish();
		end
		repeat (4) @(negedge clk_sys_in);
	endtask
	initial begin
		exp = 16'h0000;
		// A real edge on reset, so the link toggle is cleared too
		#1;
		reset_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		chk("status_reset", exp, status);
		cmd({OP_STAT_WR, 8'h1C, 24'h0}, 16);
		chk("write_no_latch", exp, status);
		cmd({OP_WRITE_UNLOCK, 32'h0}, 8);
		exp = 16'h0002;
		chk("latch_set", exp, status);
		cmd({OP_STAT_RD_LO, 32'h0}, 16);
		chk("read_mode0", exp[7:0], rx);
		cmd({OP_STAT_RD_LO, 32'h0}, 16, 1'b1);
		chk("read_mode3", exp[7:0], rx);
		cmd({8'hFF, OP_STAT_RD_LO, 24'h0}, 24);
		chk("unknown_float", 0, u_host.oe_seen_r);
		busy_len = 0;
		cmd({OP_QUAD_PROG, 32'h0}, 40);
		chk("quad_refused", 0, n_start + busy_len);
		cmd({OP_STAT_WR, 8'h04, 24'h0}, 16);
		exp = 16'h0004;
		chk("protect_written", exp, status);
		chk("status_busy_len", SW_CYC, busy_len);
		cmd({OP_WRITE_UNLOCK, 32'h0}, 8);
		cmd({OP_BLOCK_ERASE, 24'h3F0000, 8'h0}, 32);
		cmd({OP_CHIP_ERASE_A, 32'h0}, 8);
		cmd({OP_CHIP_ERASE_B, 32'h0}, 8);
		exp = 16'h0006;
		chk("protected_refused", 0, n_start);
		chk("protected_latch", exp, status);
		busy_len = 0;
		cmd({OP_BLOCK_ERASE, 24'h000000, 8'h0}, 32);
		exp = 16'h0004;
		chk("erase_op", {OP_BLOCK_ERASE, 24'h0}, last_op);
		chk("erase_busy_len", ER_CYC, busy_len);
		chk("erase_latch", exp, status);
		cmd({OP_WRITE_UNLOCK, 32'h0}, 8);
		exp = 16'h0006;
		cmd({OP_STAT_RD_LO, 32'h0}, 16, 1'b0, 10);
		chk("read_across_pause", exp[7:0], rx);
		chk("pause_float", 0, u_host.oe_in_hold_r);
		cmd({OP_STAT_WR, 8'h84, 24'h0}, 16);
		exp = 16'h0084;
		chk("guard_pin_mode", exp, status);
		cmd({OP_WRITE_UNLOCK, 32'h0}, 8);
		u_host.wp_n_r = 1'b0;
		cmd({OP_STAT_WR, 8'h00, 24'h0}, 16);
		u_host.wp_n_r = 1'b1;
		exp = 16'h0086;
		chk("guard_pin_lock", exp, status);
		cmd({OP_STAT_WR, 16'h0401, 16'h0}, 24);
		exp = 16'h0104;
		chk("power_mode_set", exp, status);
		cmd({OP_WRITE_UNLOCK, 32'h0}, 8);
		cmd({OP_STAT_WR, 8'h00, 24'h0}, 16);
		exp = 16'h0106;
		chk("power_lock", exp, status);
		power_cycle_in = 1'b1;
		@(negedge clk_sys_in);
		power_cycle_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		exp = 16'h0004;
		chk("power_cycle", exp, status);
		tally_and_finish();
	end
endmodule // tb_top
